// [pkg/flash_status_pkg.sv]
// Purpose: shared constants and types of the flash status read logic
// Assumes: one 10 MHz clock for both ends
// Notes:   only address bits 11..0 take part in command decoding
package flash_status_pkg;
   localparam int          CLK_PERIOD_NS   = 100;
   localparam int          T_ERASE_WIN_NS  = 100000;
   localparam int          ERASE_WIN_CYC   = (T_ERASE_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          NUM_PRIMARY     = 8;
   localparam int          NUM_SECONDARY   = 4;
   localparam int          NUM_SECT        = NUM_PRIMARY + NUM_SECONDARY;
   localparam int          SECT_W          = 4;
   localparam int          ADDR_W          = 16;
   localparam logic [11:0] ADDR_UNLOCK1    = 12'h555;
   localparam logic [11:0] ADDR_UNLOCK2    = 12'haaa;
   localparam logic [11:0] QUERY_MASK      = 12'h043;
   localparam logic [11:0] QUERY_MATCH     = 12'h002;
   localparam logic [7:0]  CMD_UNLOCK1     = 8'haa;
   localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
   localparam logic [7:0]  CMD_QUERY       = 8'h90;
   localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;
   localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0]  CMD_SECT_ERASE  = 8'h30;
   localparam logic [7:0]  CMD_BULK_ERASE  = 8'h10;
   localparam logic [7:0]  CMD_RESET       = 8'hf0;
   localparam logic [7:0]  PROT_YES        = 8'h01;
   localparam logic [7:0]  PROT_NO         = 8'h00;
   localparam logic [7:0]  ERASED_BYTE     = 8'hff;
   localparam int          POLL_BIT        = 7;
   localparam int          TOGGLE_BIT      = 6;
   localparam int          ERROR_BIT       = 5;
   localparam int          WINDOW_BIT      = 3;
   localparam int          STEPS_PROGRAM   = 4;
   localparam int          STEPS_ERASE     = 6;
   localparam int          STEPS_QUERY     = 4;

   typedef enum logic [2:0] {
      OP_READ       = 3'h0,
      OP_PROGRAM    = 3'h1,
      OP_SECT_ERASE = 3'h2,
      OP_BULK_ERASE = 3'h3,
      OP_QUERY      = 3'h4,
      OP_RESET      = 3'h5,
      OP_WAIT       = 3'h6
   } op_t;
endpackage

// [pkg/flash_bus_if.sv]
// Purpose: microcontroller side flash bus between master and device
// Assumes: both ends on core_clk, read data bus split into data and enable
// Notes:   strobes are active low, sector selects active high
`timescale 1ns/100ps
`default_nettype none
interface flash_bus_if;
   import flash_status_pkg::*;
   logic [NUM_PRIMARY-1:0]   primary_sector_selects;
   logic [NUM_SECONDARY-1:0] secondary_sector_selects;
   logic [ADDR_W-1:0]        addr;
   logic [7:0]               wdata;
   logic                     control_line_zero_n;
   logic                     read_strobe_n;
   logic [7:0]               rdata;
   logic                     rdata_oe;

   modport device (
      input  primary_sector_selects,
      input  secondary_sector_selects,
      input  addr,
      input  wdata,
      input  control_line_zero_n,
      input  read_strobe_n,
      output rdata,
      output rdata_oe
   );
   modport master (
      output primary_sector_selects,
      output secondary_sector_selects,
      output addr,
      output wdata,
      output control_line_zero_n,
      output read_strobe_n,
      input  rdata,
      input  rdata_oe
   );
endinterface
`default_nettype wire

// [core/flash_cycle_timer.sv]
// Purpose: reloadable down counter giving a one-cycle expiry pulse
// Assumes: load has priority over counting
// Notes:   a load of zero never expires
`timescale 1ns/100ps
`default_nettype none
module flash_cycle_timer #(
   parameter int W = 16
) (
   input  wire logic         core_clk,
   input  wire logic         reset,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output var  logic         expired
);
   logic [W-1:0] cnt_ff;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_ff  <= '0;
         expired <= 1'b0;
      end else begin
         expired <= ~load & (cnt_ff == W'(1));
         if (load) begin
            cnt_ff <= load_val;
         end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - W'(1);
         end
      end
   end
endmodule
`default_nettype wire

// [core/flash_status_dev.sv]
// Purpose: flash read side: array reads, protection query, embedded status
// Assumes: master on core_clk; write taken on strobe rising edge
// Notes:   program and erase are timed models of the embedded algorithm
`timescale 1ns/100ps
`default_nettype none
module flash_status_dev
   import flash_status_pkg::*;
#(
   parameter int SECTOR_WORDS      = 16,
   parameter int PROG_CYCLES       = 20,
   parameter int PROG_LIMIT_CYCLES = 40,
   parameter int ERASE_CYCLES      = 50
) (
   input  wire logic                          core_clk,
   input  wire logic                          reset,
   flash_bus_if.device                        bus,
   input  wire logic [flash_status_pkg::NUM_SECT-1:0] sector_protect,
   output var  logic                          busy,
   output var  logic                          error_flag
);
   import flash_status_pkg::*;
   localparam int AW = $clog2(SECTOR_WORDS);
   localparam int IW = SECT_W + AW;

   typedef enum logic [12:0] {
      ST_READ   = 13'h0001,
      ST_UNL1   = 13'h0002,
      ST_UNL2   = 13'h0004,
      ST_QUERY  = 13'h0008,
      ST_ERS1   = 13'h0010,
      ST_ERS2   = 13'h0020,
      ST_ERS3   = 13'h0040,
      ST_WINDOW = 13'h0080,
      ST_ARM    = 13'h0100,
      ST_PROG   = 13'h0200,
      ST_ERASE  = 13'h0400,
      ST_FAKE   = 13'h0800,
      ST_ERR    = 13'h1000
   } state_t;

   function automatic logic [SECT_W-1:0] sect_of(input logic [NUM_SECT-1:0] s);
      logic [SECT_W-1:0] r;
      r = '0;
      for (int i = NUM_SECT - 1; i >= 0; i--) begin
         if (s[i]) begin
            r = SECT_W'(i);
         end
      end
      return r;
   endfunction

   function automatic logic is_status(input state_t st);
      return st inside {ST_WINDOW, ST_PROG, ST_ERASE, ST_FAKE, ST_ERR};
   endfunction

   state_t              state_ff;
   state_t              nxt_state;
   logic [7:0]          mem [NUM_SECT*SECTOR_WORDS];
   logic [NUM_SECT-1:0] sel;
   logic                sel_any;
   logic                wr_q_ff;
   logic                rd_q_ff;
   logic                wr_evt;
   logic                rd_evt;
   logic [11:0]         a12;
   logic [7:0]          d;
   logic [IW-1:0]       idx;
   logic [SECT_W-1:0]   sect;
   logic [NUM_SECT-1:0] mask_ff;
   logic [IW-1:0]       prog_idx_ff;
   logic [7:0]          prog_data_ff;
   logic                prog_fail_ff;
   logic                toggle_ff;
   logic                error_ff;
   logic                load;
   logic [15:0]         load_val;
   logic                expired;
   logic [7:0]          rd_val;
   logic [7:0]          rdata_ff;
   logic                rdata_oe_ff;

   assign sel     = {bus.secondary_sector_selects, bus.primary_sector_selects};
   assign sel_any = |sel;
   assign a12     = bus.addr[11:0];
   assign d       = bus.wdata;
   assign sect    = sect_of(sel);
   assign idx     = {sect, bus.addr[AW-1:0]};
   assign wr_evt  = ~wr_q_ff & bus.control_line_zero_n & sel_any;
   assign rd_evt  = rd_q_ff & ~bus.read_strobe_n & sel_any;
   assign bus.rdata    = rdata_ff;
   assign bus.rdata_oe = rdata_oe_ff;
   assign error_flag   = error_ff;

   flash_cycle_timer #(
      .W (16)
   ) u_timer (
      .core_clk (core_clk),
      .reset    (reset),
      .load     (load),
      .load_val (load_val),
      .expired  (expired)
   );

   always_comb begin
      nxt_state = state_ff;
      load      = 1'b0;
      load_val  = '0;
      case (state_ff)
         ST_READ: begin
            if (wr_evt && d == CMD_UNLOCK1 && a12 == ADDR_UNLOCK1) begin
               nxt_state = ST_UNL1;
            end
         end
         ST_UNL1: begin
            if (wr_evt) begin
               nxt_state = (d == CMD_UNLOCK2 && a12 == ADDR_UNLOCK2) ? ST_UNL2 : ST_READ;
            end
         end
         ST_UNL2: begin
            if (wr_evt) begin
               nxt_state = ST_READ;
               if (a12 == ADDR_UNLOCK1 && d == CMD_QUERY) nxt_state = ST_QUERY;
               if (a12 == ADDR_UNLOCK1 && d == CMD_PROGRAM) nxt_state = ST_ARM;
               if (a12 == ADDR_UNLOCK1 && d == CMD_ERASE_SETUP) nxt_state = ST_ERS1;
            end
         end
         ST_QUERY, ST_ERR: begin
            if (wr_evt && d == CMD_RESET) begin
               nxt_state = ST_READ;
            end
         end
         ST_ARM: begin
            if (wr_evt) begin
               if (sector_protect[sect]) begin
                  nxt_state = ST_READ;
               end else begin
                  nxt_state = ST_PROG;
                  load      = 1'b1;
                  load_val  = 16'(PROG_CYCLES);
               end
            end
         end
         ST_ERS1: begin
            if (wr_evt) begin
               nxt_state = (d == CMD_UNLOCK1 && a12 == ADDR_UNLOCK1) ? ST_ERS2 : ST_READ;
            end
         end
         ST_ERS2: begin
            if (wr_evt) begin
               nxt_state = (d == CMD_UNLOCK2 && a12 == ADDR_UNLOCK2) ? ST_ERS3 : ST_READ;
            end
         end
         ST_ERS3, ST_WINDOW: begin
            if (wr_evt && d == CMD_SECT_ERASE) begin
               nxt_state = ST_WINDOW;
               load      = 1'b1;
               load_val  = 16'(ERASE_WIN_CYC);
            end else if (wr_evt && state_ff == ST_ERS3 && d == CMD_BULK_ERASE && a12 == ADDR_UNLOCK1) begin
               nxt_state = (&sector_protect) ? ST_FAKE : ST_ERASE;
               load      = 1'b1;
               load_val  = (&sector_protect) ? 16'(ERASE_WIN_CYC) : 16'(ERASE_CYCLES);
            end else if (wr_evt) begin
               nxt_state = ST_READ;
            end else if (expired && state_ff == ST_WINDOW) begin
               nxt_state = (mask_ff == '0) ? ST_FAKE : ST_ERASE;
               load      = 1'b1;
               load_val  = (mask_ff == '0) ? 16'(ERASE_WIN_CYC) : 16'(ERASE_CYCLES);
            end
         end
         ST_PROG: begin
            if (expired) begin
               nxt_state = prog_fail_ff ? ST_ERR : ST_READ;
            end
         end
         ST_ERASE, ST_FAKE: begin
            if (expired) begin
               nxt_state = ST_READ;
            end
         end
         default: nxt_state = ST_READ;
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_ff <= ST_READ;
         busy     <= 1'b0;
         wr_q_ff  <= 1'b1;
         rd_q_ff  <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         busy     <= is_status(nxt_state);
         wr_q_ff  <= bus.control_line_zero_n;
         rd_q_ff  <= bus.read_strobe_n;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prog_idx_ff  <= '0;
         prog_data_ff <= ERASED_BYTE;
         prog_fail_ff <= 1'b0;
      end else if (state_ff == ST_ARM && wr_evt) begin
         prog_idx_ff  <= idx;
         prog_data_ff <= d;
         prog_fail_ff <= (|(~mem[idx] & d)) || (PROG_CYCLES > PROG_LIMIT_CYCLES);
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mask_ff <= '0;
      end else if (state_ff == ST_ERS3 && wr_evt) begin
         mask_ff <= (d == CMD_SECT_ERASE) ? (sel & ~sector_protect) : ~sector_protect;
      end else if (state_ff == ST_WINDOW && wr_evt && d == CMD_SECT_ERASE) begin
         mask_ff <= mask_ff | (sel & ~sector_protect);
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         error_ff <= 1'b0;
      end else if (state_ff == ST_PROG && expired && prog_fail_ff) begin
         error_ff <= 1'b1;
      end else if (wr_evt && d == CMD_RESET && state_ff inside {ST_READ, ST_QUERY, ST_ERR}) begin
         error_ff <= 1'b0;
      end
   end

   // array is reset to the erased value so reads are defined from the start
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_SECT * SECTOR_WORDS; i++) begin
            mem[i] <= ERASED_BYTE;
         end
      end else if (state_ff == ST_PROG && expired) begin
         mem[prog_idx_ff] <= mem[prog_idx_ff] & prog_data_ff;
      end else if (state_ff == ST_ERASE && expired) begin
         for (int s = 0; s < NUM_SECT; s++) begin
            for (int w = 0; w < SECTOR_WORDS; w++) begin
               if (mask_ff[s]) begin
                  mem[s*SECTOR_WORDS+w] <= ERASED_BYTE;
               end
            end
         end
      end
   end

   always_comb begin
      rd_val = mem[idx];
      if (is_status(state_ff)) begin
         rd_val             = '0;
         rd_val[TOGGLE_BIT] = toggle_ff;
         rd_val[ERROR_BIT]  = error_ff;
         rd_val[WINDOW_BIT] = (state_ff != ST_WINDOW);
         rd_val[POLL_BIT]   = (state_ff == ST_PROG || state_ff == ST_ERR) ? ~prog_data_ff[7] : 1'b0;
      end else if (state_ff == ST_QUERY && (a12 & QUERY_MASK) == QUERY_MATCH) begin
         rd_val = sector_protect[sect] ? PROT_YES : PROT_NO;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         toggle_ff   <= 1'b0;
         rdata_ff    <= '0;
         rdata_oe_ff <= 1'b0;
      end else begin
         rdata_oe_ff <= ~bus.read_strobe_n & sel_any;
         if (rd_evt) begin
            rdata_ff <= rd_val;
            if (is_status(state_ff)) begin
               toggle_ff <= ~toggle_ff;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [core/flash_status_host.sv]
// Purpose: bus master end issuing flash command sequences for a user port
// Assumes: one command at a time; device on the same core_clk
// Notes:   wait op reads until two successive reads agree
`timescale 1ns/100ps
`default_nettype none
module flash_status_host
   import flash_status_pkg::*;
(
   input  wire logic                          core_clk,
   input  wire logic                          reset,
   flash_bus_if.master                        bus,
   input  wire logic                          cmd_valid,
   input  wire flash_status_pkg::op_t         cmd_op,
   input  wire logic [flash_status_pkg::ADDR_W-1:0]   cmd_addr,
   input  wire logic [7:0]                    cmd_data,
   input  wire logic [flash_status_pkg::NUM_SECT-1:0] cmd_sel,
   output var  logic                          cmd_ready,
   output var  logic                          rsp_valid,
   output var  logic [7:0]                    rsp_data
);
   import flash_status_pkg::*;

   typedef enum logic [5:0] {
      H_IDLE  = 6'h01,
      H_ISSUE = 6'h02,
      H_WLO   = 6'h04,
      H_WHI   = 6'h08,
      H_RLO   = 6'h10,
      H_RCAP  = 6'h20
   } hstate_t;

   function automatic logic [2:0] last_step(input op_t op);
      case (op)
         OP_PROGRAM:    return 3'(STEPS_PROGRAM - 1);
         OP_QUERY:      return 3'(STEPS_QUERY - 1);
         OP_SECT_ERASE: return 3'(STEPS_ERASE - 1);
         OP_BULK_ERASE: return 3'(STEPS_ERASE - 1);
         default:       return 3'h0;
      endcase
   endfunction

   // returns {is_read, address, data} of one bus cycle
   function automatic logic [24:0] step_of(input op_t op, input logic [2:0] i,
                                           input logic [15:0] a, input logic [7:0] dv);
      logic [24:0] r;
      r = {1'b0, 4'h0, ADDR_UNLOCK1, CMD_UNLOCK1};
      case (i)
         3'h0: begin
            if (op == OP_READ || op == OP_WAIT) r = {1'b1, a, 8'h00};
            if (op == OP_RESET) r = {1'b0, a, CMD_RESET};
         end
         3'h1: r = {1'b0, 4'h0, ADDR_UNLOCK2, CMD_UNLOCK2};
         3'h2: begin
            r[7:0] = (op == OP_PROGRAM) ? CMD_PROGRAM : (op == OP_QUERY) ? CMD_QUERY : CMD_ERASE_SETUP;
         end
         3'h3: begin
            if (op == OP_PROGRAM) r = {1'b0, a, dv};
            if (op == OP_QUERY) r = {1'b1, a, 8'h00};
         end
         3'h4: r = {1'b0, 4'h0, ADDR_UNLOCK2, CMD_UNLOCK2};
         default: begin
            r = (op == OP_SECT_ERASE) ? {1'b0, a, CMD_SECT_ERASE} : {1'b0, 4'h0, ADDR_UNLOCK1, CMD_BULK_ERASE};
         end
      endcase
      return r;
   endfunction

   hstate_t             state_ff;
   op_t                 op_ff;
   logic [15:0]         addr_ff;
   logic [7:0]          data_ff;
   logic [NUM_SECT-1:0] sel_ff;
   logic [2:0]          step_ff;
   logic                have_prev_ff;
   logic [7:0]          prev_ff;
   logic [24:0]         cur;
   logic                last;

   assign cur  = step_of(op_ff, step_ff, addr_ff, data_ff);
   assign last = (step_ff == last_step(op_ff));

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_ff                     <= H_IDLE;
         op_ff                        <= OP_READ;
         addr_ff                      <= '0;
         data_ff                      <= '0;
         sel_ff                       <= '0;
         step_ff                      <= '0;
         have_prev_ff                 <= 1'b0;
         prev_ff                      <= '0;
         cmd_ready                    <= 1'b1;
         rsp_valid                    <= 1'b0;
         rsp_data                     <= '0;
         bus.primary_sector_selects   <= '0;
         bus.secondary_sector_selects <= '0;
         bus.addr                     <= '0;
         bus.wdata                    <= '0;
         bus.control_line_zero_n      <= 1'b1;
         bus.read_strobe_n            <= 1'b1;
      end else begin
         rsp_valid <= 1'b0;
         case (state_ff)
            H_IDLE: begin
               if (cmd_valid) begin
                  op_ff        <= cmd_op;
                  addr_ff      <= cmd_addr;
                  data_ff      <= cmd_data;
                  sel_ff       <= cmd_sel;
                  step_ff      <= '0;
                  have_prev_ff <= 1'b0;
                  cmd_ready    <= 1'b0;
                  state_ff     <= H_ISSUE;
               end
            end
            H_ISSUE: begin
               {bus.secondary_sector_selects, bus.primary_sector_selects} <= sel_ff;
               bus.addr  <= cur[23:8];
               bus.wdata <= cur[7:0];
               if (cur[24]) begin
                  bus.read_strobe_n <= 1'b0;
                  state_ff          <= H_RLO;
               end else begin
                  bus.control_line_zero_n <= 1'b0;
                  state_ff                <= H_WLO;
               end
            end
            H_WLO: begin
               bus.control_line_zero_n <= 1'b1;
               state_ff                <= H_WHI;
            end
            H_WHI, H_RCAP: begin
               if (state_ff == H_RCAP) begin
                  bus.read_strobe_n <= 1'b1;
                  rsp_data          <= bus.rdata;
                  prev_ff           <= bus.rdata;
                  have_prev_ff      <= 1'b1;
               end
               if (op_ff == OP_WAIT) begin
                  if (have_prev_ff && bus.rdata == prev_ff) begin
                     state_ff <= H_IDLE;
                  end else begin
                     state_ff <= H_ISSUE;
                  end
               end else if (last) begin
                  state_ff <= H_IDLE;
               end else begin
                  step_ff  <= step_ff + 3'h1;
                  state_ff <= H_ISSUE;
               end
               if ((op_ff != OP_WAIT && last) || (op_ff == OP_WAIT && have_prev_ff && bus.rdata == prev_ff)) begin
                  rsp_valid <= 1'b1;
                  cmd_ready <= 1'b1;
                  {bus.secondary_sector_selects, bus.primary_sector_selects} <= '0;
               end
            end
            H_RLO: state_ff <= H_RCAP;
            default: state_ff <= H_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [tb/flash_status_checker.sv]
// Purpose: bus checks between flash master and flash device
// Assumes: both ends on one core_clk
// Notes:   sees only the shared flash bus signals
`timescale 1ns/100ps
`default_nettype none
module flash_status_checker (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic [7:0]  primary_sector_selects,
   input wire logic [3:0]  secondary_sector_selects,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        control_line_zero_n,
   input wire logic        read_strobe_n,
   input wire logic [7:0]  rdata,
   input wire logic        rdata_oe
);
   wire logic sel = (|primary_sector_selects) | (|secondary_sector_selects);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence w_aa;
      $rose(control_line_zero_n) && wdata == 8'haa && addr[11:0] == 12'h555;
   endsequence
   sequence w_qry;
      $rose(control_line_zero_n) && wdata == 8'h90 && addr[11:0] == 12'h555;
   endsequence
   // second reset edge on: the host flops have surely taken their reset values
   rst_idle_a: assert property (disable iff (1'b0) reset && $past(reset) |-> !sel && control_line_zero_n)
      else $error("bus active during reset");
   oe_follow_a: assert property (rdata_oe == $past(!read_strobe_n && sel))
      else $error("read enable not tied to strobe and select");
   wr_sel_a: assert property (!control_line_zero_n |-> sel)
      else $error("write strobe without select");
   wr_pulse_a: assert property ($fell(control_line_zero_n) |=> control_line_zero_n && $stable(addr))
      else $error("write pulse not one cycle");
   rd_pulse_a: assert property ($fell(read_strobe_n) |=> !read_strobe_n ##1 read_strobe_n)
      else $error("read pulse not two cycles");
   rd_hold_a: assert property (!$fell(read_strobe_n) |=> $stable(rdata))
      else $error("read data moved without read");
   unlock_pair_a: assert property (w_aa |-> ##3 $rose(control_line_zero_n) && wdata == 8'h55)
      else $error("second coded write missing");
   query_val_a: assert property (w_qry |-> ##2 $fell(read_strobe_n) ##1 rdata[7:1] == 7'h00)
      else $error("query read not 00 or 01");
endmodule
`default_nettype wire

// [tb/tb_flash_status_read_logic.sv]
// Purpose: drives host user port, judges replies
// Assumes: default device timing parameters
// Notes:   sector 1 held protected
`timescale 1ns/100ps
`default_nettype none
module tb_flash_status_read_logic;
   import flash_status_pkg::*;
   logic        core_clk, reset, cmd_valid, cmd_ready, rsp_valid, busy, error_flag;
   op_t         cmd_op;
   logic [15:0] cmd_addr;
   logic [7:0]  cmd_data, rsp_data, rd, t;
   logic [11:0] cmd_sel, sector_protect;
   int          miscompares, cmp_count;
   flash_bus_if bus_if ();
   flash_status_dev i_flash_status_dev (.core_clk(core_clk), .reset(reset), .bus(bus_if.device),
      .sector_protect(sector_protect), .busy(busy), .error_flag(error_flag));
   flash_status_host i_flash_status_host (.core_clk(core_clk), .reset(reset), .bus(bus_if.master),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_sel(cmd_sel),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   flash_status_checker i_flash_status_checker (.core_clk(core_clk), .reset(reset),
      .primary_sector_selects(bus_if.primary_sector_selects),
      .secondary_sector_selects(bus_if.secondary_sector_selects), .addr(bus_if.addr),
      .wdata(bus_if.wdata), .control_line_zero_n(bus_if.control_line_zero_n),
      .read_strobe_n(bus_if.read_strobe_n), .rdata(bus_if.rdata), .rdata_oe(bus_if.rdata_oe));
   task automatic end_sim;
      $display("compares %0d miscompares %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
      cmp_count++;
      if ((got & m) !== (exp & m)) begin
         miscompares++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input op_t op, input logic [15:0] a, input logic [7:0] d, input int s);
      int n;
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_sel = 12'h001 << s;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      chk({7'h00, cmd_ready}, 8'h00, 8'h01);
      n = 0;
      while (rsp_valid !== 1'b1 && n < 4000) begin
         @(negedge core_clk);
         n++;
      end
      if (rsp_valid !== 1'b1) begin
         miscompares++;
         $display("ERROR %0t: no response from host", $time);
         end_sim();
      end
      rd = rsp_data;
   endtask
   task automatic rdb(input logic [15:0] a, input int s);
      cmd(OP_READ, a, 8'h00, s);
   endtask
   task automatic test_query;
      rdb(16'h0002, 0);
      chk(rd, 8'hff, 8'hff);
      cmd(OP_QUERY, 16'h0002, 8'h00, 1);
      chk(rd, 8'h01, 8'hff);
      cmd(OP_RESET, 16'h0000, CMD_RESET, 1);
      cmd(OP_QUERY, 16'h0002, 8'h00, 0);
      chk(rd, 8'h00, 8'hff);
      cmd(OP_RESET, 16'h0000, CMD_RESET, 0);
      rdb(16'h0002, 0);
      chk(rd, 8'hff, 8'hff);
      $display("done query");
   endtask
   task automatic test_prog;
      cmd(OP_PROGRAM, 16'h0003, 8'h5a, 0);
      rdb(16'h0003, 0);
      chk(rd, 8'h88, 8'ha8);
      t = rd;
      rdb(16'h0003, 0);
      chk(rd, t ^ 8'h40, 8'h40);
      chk({7'h00, busy}, 8'h01, 8'h01);
      cmd(OP_WAIT, 16'h0003, 8'h00, 0);
      rdb(16'h0003, 0);
      chk(rd, 8'h5a, 8'hff);
      cmd(OP_PROGRAM, 16'h0003, 8'h00, 1);
      rdb(16'h0003, 1);
      chk(rd, 8'hff, 8'hff);
      $display("done program");
   endtask
   task automatic test_error;
      cmd(OP_PROGRAM, 16'h0003, 8'hff, 0);
      repeat (25) @(negedge core_clk);
      rdb(16'h0003, 0);
      chk(rd, 8'h20, 8'ha0);
      rdb(16'h0003, 0);
      chk({7'h00, error_flag}, 8'h01, 8'h01);
      cmd(OP_RESET, 16'h0000, CMD_RESET, 0);
      chk({7'h00, error_flag}, 8'h00, 8'h01);
      rdb(16'h0003, 0);
      chk(rd, 8'h5a, 8'hff);
      $display("done error");
   endtask
   task automatic test_erase;
      // failed sector 0 is left alone from here on
      cmd(OP_PROGRAM, 16'h0005, 8'h00, 2);
      cmd(OP_WAIT, 16'h0005, 8'h00, 2);
      cmd(OP_SECT_ERASE, 16'h0000, CMD_SECT_ERASE, 2);
      rdb(16'h0000, 2);
      chk(rd, 8'h00, 8'h88);
      repeat (975) @(negedge core_clk);
      rdb(16'h0000, 2);
      chk(rd, 8'h00, 8'h08);
      repeat (20) @(negedge core_clk);
      rdb(16'h0000, 2);
      chk(rd, 8'h08, 8'h88);
      cmd(OP_WAIT, 16'h0000, 8'h00, 2);
      rdb(16'h0005, 2);
      chk(rd, 8'hff, 8'hff);
      cmd(OP_SECT_ERASE, 16'h0000, CMD_SECT_ERASE, 1);
      rdb(16'h0000, 1);
      chk(rd, 8'h00, 8'h80);
      t = rd;
      rdb(16'h0000, 1);
      chk(rd, t ^ 8'h40, 8'h40);
      cmd(OP_WAIT, 16'h0000, 8'h00, 1);
      rdb(16'h0000, 1);
      chk(rd, 8'hff, 8'hff);
      $display("done erase");
   endtask
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   initial begin
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = OP_READ;
      cmd_addr = 16'h0000;
      cmd_data = 8'h00;
      cmd_sel = 12'h000;
      sector_protect = 12'h002;
      miscompares = 0;
      cmp_count = 0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      reset = 1'b0;
      test_query();
      test_prog();
      test_error();
      test_erase();
      end_sim();
   end
endmodule
`default_nettype wire
